// ==== rtl/digital_loop_core.sv ====
// Digital loop core: dividers, comparator, loop filter, acquisition, holdover, switchover
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RQ1] Output tuning word tracks the selected reference, A or B.
// [RQ2] Selected reference divided by programmable integer feedforward ratio.
// [RQ3] Divided reference feeds the comparator at reference rate over ratio.
// [RQ4] Loop filter words drive the synthesizer tuning word.
// [RQ5] Feedback divider makes oscillator run at ratio times comparator rate.
// [RQ6] Optional frequency estimator shortens acquisition; else phase loop alone.
// [RQ7] Phase loop idle while estimator measures comparator input period.
// [RQ8] Estimate loaded to synthesizer as comparator rate times feedback ratio.
// [RQ9] After load the phase loop servoes to acquire and hold lock.
// [RQ10] Manual and automatic holdover modes both supported.
// [RQ11] Holdover output continues while system clock runs.
// [RQ12] Holdover tuning word is average of prior steady output.
// [RQ13] Manual and automatic reference switchover supported.
// [RQ14] Configuring party keeps tuning word at or below 40 percent.
// [RQ15] Choice line: outside drives in manual, device in auto; low is A.
// [RQ16] Holdover line active high; forced in manual, reported in auto.
// [RQ17] Servo starts only after the estimate is written to tuning word; in holdover at the load step the write is skipped and servo still follows.
module digital_loop_core
    import dpll_core_pkg::*;
#(
    parameter int FTW_WIDTH = FTW_W,
    parameter int DIV_WIDTH = DIV_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic reference_input_a,
    input wire logic reference_input_b,
    input wire logic feedback_in,
    input wire logic ref_a_lost,
    input wire logic ref_b_lost,
    input wire logic [DIV_WIDTH-1:0] ff_ratio,
    input wire logic [DIV_WIDTH-1:0] fb_ratio,
    input wire logic [FTW_WIDTH-1:0] ftw_per_hz_cycle,
    input wire logic estimator_enable,
    input wire logic auto_holdover,
    input wire logic auto_switchover,
    input wire logic reference_choice_line_in,
    output logic reference_choice_line_out,
    output logic reference_choice_line_oe,
    input wire logic holdover_line_in,
    output logic holdover_line_out,
    output logic holdover_line_oe,
    output logic [FTW_WIDTH-1:0] tuning_word,
    output logic comparator_tick,
    output logic in_servo
);
    ////////////////////////////////////////////////////////////////////
    logic rst_m, rst_n;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // Two-flop synchronisers for pins
    logic [4:0] sync1, sync2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (clk_en) begin
            sync1 <= {reference_input_a, reference_input_b, feedback_in,
                      reference_choice_line_in, holdover_line_in};
            sync2 <= sync1;
        end
    end
    logic ra, rb, fbk, sel_pin, hold_pin;
    assign {ra, rb, fbk, sel_pin, hold_pin} = sync2;

    function automatic logic [DIV_WIDTH-1:0] next_div(input logic [DIV_WIDTH-1:0] c,
                                                     input logic [DIV_WIDTH-1:0] m);
        next_div = (c + DIV_ONE >= m) ? '0 : c + DIV_ONE;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Reference selection and holdover
    logic active_sel, holdover;
    logic sel_ref_lost;
    assign sel_ref_lost = active_sel ? ref_b_lost : ref_a_lost;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_sel <= REF_A;
        end else if (clk_en) begin
            if (!auto_switchover) begin
                active_sel <= sel_pin; // [RQ13] [RQ15]
            end else if (sel_ref_lost && !(active_sel ? ref_a_lost : ref_b_lost)) begin
                active_sel <= ~active_sel; // [RQ13]
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            holdover <= 1'b0;
        end else if (clk_en) begin
            if (!auto_holdover) begin
                holdover <= hold_pin; // [RQ10] [RQ16]
            end else begin
                holdover <= ref_a_lost && ref_b_lost; // [RQ10]
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reference_choice_line_out <= REF_A;
            reference_choice_line_oe <= 1'b0;
            holdover_line_out <= 1'b0;
            holdover_line_oe <= 1'b0;
        end else if (clk_en) begin
            reference_choice_line_out <= active_sel; // [RQ15]
            reference_choice_line_oe <= auto_switchover; // [RQ15]
            holdover_line_out <= holdover; // [RQ16]
            holdover_line_oe <= auto_holdover; // [RQ16]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Feedforward and feedback dividers
    logic ref_prev, fb_prev, ref_rise, fb_rise;
    logic [DIV_WIDTH-1:0] ff_cnt, fb_cnt;
    logic ff_tick, fb_tick;
    logic ref_now;
    assign ref_now = (active_sel == REF_B) ? rb : ra; // [RQ1]
    assign ref_rise = ref_now && !ref_prev;
    assign fb_rise = fbk && !fb_prev;
    assign ff_tick = ref_rise && (next_div(ff_cnt, ff_ratio) == '0);
    assign fb_tick = fb_rise && (next_div(fb_cnt, fb_ratio) == '0);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_prev <= 1'b0;
            fb_prev <= 1'b0;
            ff_cnt <= '0;
            fb_cnt <= '0;
            comparator_tick <= 1'b0;
        end else if (clk_en) begin
            ref_prev <= ref_now;
            fb_prev <= fbk;
            if (ref_rise) begin
                ff_cnt <= next_div(ff_cnt, ff_ratio); // [RQ2]
            end
            if (fb_rise) begin
                fb_cnt <= next_div(fb_cnt, fb_ratio); // [RQ5]
            end
            comparator_tick <= ff_tick; // [RQ3]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Phase comparator: signed count, up on a lone divided reference tick, down on a lone divided feedback tick, cleared when both tick together
    logic signed [PHASE_W-1:0] phase_err;
    logic err_valid;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_err <= '0;
            err_valid <= 1'b0;
        end else if (clk_en) begin
            err_valid <= ff_tick && fb_tick;
            if (ff_tick && fb_tick) begin
                phase_err <= '0;
                err_valid <= 1'b1;
            end else if (ff_tick) begin
                phase_err <= phase_err + PHASE_W'(1); // [RQ3]
                err_valid <= 1'b1;
            end else if (fb_tick) begin
                phase_err <= phase_err - PHASE_W'(1);
                err_valid <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Acquisition sequencer
    acq_state_t state;
    logic [EST_CYCLES_W-1:0] period_cnt, period;
    logic est_done;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_cnt <= '0;
            period <= '0;
            est_done <= 1'b0;
        end else if (clk_en) begin
            est_done <= 1'b0;
            if (state != ST_ESTIMATE) begin
                period_cnt <= '0;
            end else if (ff_tick) begin
                if (period_cnt != '0) begin
                    period <= period_cnt; // [RQ7]
                    est_done <= 1'b1;
                end
                period_cnt <= EST_CYCLES_W'(1);
            end else if (period_cnt != '0) begin
                // Count only once a divided edge has opened the window
                period_cnt <= period_cnt + EST_CYCLES_W'(1);
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else if (clk_en) begin
            case (state)
                ST_IDLE: state <= estimator_enable ? ST_ESTIMATE : ST_SERVO; // [RQ6]
                ST_ESTIMATE: if (est_done) state <= ST_LOAD; // [RQ7]
                ST_LOAD: state <= ST_SERVO; // [RQ17]
                ST_SERVO: state <= ST_SERVO; // [RQ9]
                default: state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Loop filter, estimate load, holdover average
    // Integer divide kept out of the loop; one multicycle-free divider only at load
    logic [FTW_WIDTH-1:0] integ, avg, est_word;
    // Product kept wide so a large scale times ratio cannot wrap before the divide
    localparam int PROD_W = FTW_WIDTH + DIV_WIDTH;
    logic [PROD_W-1:0] est_prod, est_div;
    assign est_prod = PROD_W'(ftw_per_hz_cycle) * PROD_W'(fb_ratio);
    // Period is zero only before the first measurement; divide by one then
    assign est_div = (period == '0) ? PROD_W'(1) : PROD_W'(period);
    assign est_word = FTW_WIDTH'(est_prod / est_div); // [RQ8]
    logic signed [FTW_WIDTH-1:0] err_ext;
    assign err_ext = FTW_WIDTH'(phase_err) <<< GAIN_SHIFT;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            integ <= FTW_RESET;
            avg <= FTW_RESET;
            tuning_word <= FTW_RESET;
            in_servo <= 1'b0;
        end else if (clk_en) begin
            in_servo <= (state == ST_SERVO) && !holdover;
            if (holdover) begin
                tuning_word <= avg; // [RQ11] [RQ12]
            end else if (state == ST_LOAD) begin
                integ <= est_word; // [RQ8] [RQ17]
                tuning_word <= est_word;
            end else if (state == ST_SERVO) begin
                if (err_valid) begin
                    integ <= integ + err_ext; // [RQ9]
                end
                tuning_word <= integ + err_ext; // [RQ4] [RQ1]
                avg <= avg + FTW_WIDTH'((signed'(integ) - signed'(avg)) >>> AVG_SHIFT);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Own count of feedback edges per tick; restarts at each tick, and its valid flag clears when the ratio moves
    logic [DIV_WIDTH-1:0] fb_edges, fb_ratio_q;
    logic fb_count_ok;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fb_edges <= '0;
            fb_ratio_q <= '0;
            fb_count_ok <= 1'b0;
        end else if (clk_en) begin
            fb_ratio_q <= fb_ratio;
            if (fb_ratio != fb_ratio_q) begin
                fb_count_ok <= 1'b0;
            end else if (fb_tick) begin
                fb_count_ok <= 1'b1;
            end
            if (fb_tick) begin
                fb_edges <= '0;
            end else if (fb_rise) begin
                fb_edges <= fb_edges + DIV_ONE;
            end
        end
    end

    // Load step: word written first, servo flagged on the following edge
    sequence s_word_loaded;
        state == ST_SERVO && tuning_word == $past(est_word);
    endsequence
    sequence s_servo_flagged;
        in_servo || $past(holdover) || !$past(clk_en);
    endsequence

    a_hold_freezes_word: assert property (@(posedge clk) disable iff (!rst_n) // [RQ12]
        clk_en && holdover |=> tuning_word == $past(avg))
        else $error("Holdover word not the average");
    a_estimate_no_servo: assert property (@(posedge clk) disable iff (!rst_n) // [RQ7]
        clk_en && state == ST_ESTIMATE && !holdover |-> !in_servo ##1 $stable(tuning_word))
        else $error("Servo active during estimate");
    a_load_before_servo: assert property (@(posedge clk) disable iff (!rst_n) // [RQ17]
        $changed(state) && state == ST_SERVO
        |-> $past(state) == ST_LOAD || !$past(estimator_enable))
        else $error("Servo without estimate load");
    a_load_then_servo: assert property (@(posedge clk) disable iff (!rst_n) // [RQ17] [RQ9]
        clk_en && state == ST_LOAD && !holdover |=> s_word_loaded ##1 s_servo_flagged)
        else $error("Servo did not follow the estimate load");
    a_sel_drive_auto: assert property (@(posedge clk) disable iff (!rst_n) // [RQ15]
        clk_en && auto_switchover |=> reference_choice_line_oe)
        else $error("Choice line not driven in auto");
    a_hold_drive_auto: assert property (@(posedge clk) disable iff (!rst_n) // [RQ16]
        clk_en && auto_holdover |=> holdover_line_oe)
        else $error("Holdover line not driven in auto");
    a_auto_hold_enter: assert property (@(posedge clk) disable iff (!rst_n) // [RQ10]
        clk_en && auto_holdover && ref_a_lost && ref_b_lost |=> holdover)
        else $error("Auto holdover not entered");
    a_switch_lost_ref: assert property (@(posedge clk) disable iff (!rst_n) // [RQ13]
        clk_en && auto_switchover && sel_ref_lost && !(active_sel ? ref_a_lost : ref_b_lost)
        |=> $changed(active_sel))
        else $error("Switchover missed");
    a_tick_follows_div: assert property (@(posedge clk) disable iff (!rst_n) // [RQ3]
        clk_en && ff_tick |=> comparator_tick)
        else $error("Comparator tick missing");
    a_fb_div_ratio: assert property (@(posedge clk) disable iff (!rst_n) // [RQ5]
        clk_en && fb_tick && fb_count_ok && fb_ratio == fb_ratio_q && fb_ratio > DIV_ONE
        |-> fb_edges == fb_ratio - DIV_ONE)
        else $error("Feedback divider ratio wrong");
    a_sel_free_manual: assert property (@(posedge clk) disable iff (!rst_n) // [RQ15]
        clk_en && !auto_switchover |=> !reference_choice_line_oe)
        else $error("Choice line driven in manual mode");
    a_hold_free_manual: assert property (@(posedge clk) disable iff (!rst_n) // [RQ16]
        clk_en && !auto_holdover |=> !holdover_line_oe)
        else $error("Holdover line driven in manual mode");
endmodule // digital_loop_core
`default_nettype wire

// ==== rtl/dpll_core_pkg.sv ====
// Package of constants and types for the digital loop core
package dpll_core_pkg;
    localparam int FTW_W = 32;
    localparam int DIV_W = 17;
    localparam int PHASE_W = 16;
    localparam int EST_CYCLES_W = 24;
    localparam int AVG_SHIFT = 4;
    localparam logic [FTW_W-1:0] FTW_RESET = 32'h0000_0000;
    localparam logic [DIV_W-1:0] DIV_ONE = 17'h0_0001;
    localparam logic [PHASE_W-1:0] GAIN_SHIFT = 16'h0004;
    localparam logic REF_A = 1'b0;
    localparam logic REF_B = 1'b1;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ESTIMATE,
        ST_LOAD,
        ST_SERVO
    } acq_state_t;
endpackage

// ==== verif/ref_source_model.sv ====
// Reference and feedback source model for the loop core
`timescale 1ns/1ps
`default_nettype none
module ref_source_model #(
    parameter int HALF = 4
) (
    input wire logic clk,
    input wire logic run_a,
    input wire logic run_b,
    output logic ref_a,
    output logic ref_b,
    output logic fb
);
    int cnt = 0;
    logic a_q = 1'b0;
    logic b_q = 1'b0;
    logic f_q = 1'b0;
    assign ref_a = a_q;
    assign ref_b = b_q;
    assign fb = f_q;
    // A lost source stops low, like a dead clock
    always @(posedge clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            a_q <= run_a ? ~a_q : 1'b0;
            b_q <= run_b ? ~b_q : 1'b0;
            f_q <= ~f_q;
        end
    end
endmodule // ref_source_model
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the digital loop core
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dpll_core_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ref_a_lost = 1'b0;
    logic ref_b_lost = 1'b0;
    logic [DIV_W-1:0] ff_ratio = 17'h0_0004;
    logic [DIV_W-1:0] fb_ratio = 17'h0_0008;
    // Scale keeps the word far under 40 percent of full range
    logic [FTW_W-1:0] ftw_scale = 32'h0000_1000;
    logic auto_holdover = 1'b0;
    logic auto_switchover = 1'b0;
    logic choice_drive = 1'b0;
    logic hold_drive = 1'b0;
    logic est_en = 1'b1;
    wire logic ref_a, ref_b, fb, c_out, c_oe, h_out, h_oe, tick, in_servo;
    wire logic [FTW_W-1:0] tuning_word;
    wire logic c_wire, h_wire;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////
    // Wire level from both drivers; no pull on either line
    assign c_wire = c_oe ? c_out : choice_drive;
    assign h_wire = h_oe ? h_out : hold_drive;
    ref_source_model ref_source_model_inst (.clk(clk), .run_a(~ref_a_lost),
        .run_b(~ref_b_lost), .ref_a(ref_a), .ref_b(ref_b), .fb(fb));
    digital_loop_core digital_loop_core_inst (.clk(clk), .resetn(resetn),
        .clk_en(1'b1), .reference_input_a(ref_a), .reference_input_b(ref_b),
        .feedback_in(fb), .ref_a_lost(ref_a_lost), .ref_b_lost(ref_b_lost),
        .ff_ratio(ff_ratio), .fb_ratio(fb_ratio), .ftw_per_hz_cycle(ftw_scale),
        .estimator_enable(est_en), .auto_holdover(auto_holdover),
        .auto_switchover(auto_switchover), .reference_choice_line_in(c_wire),
        .reference_choice_line_out(c_out), .reference_choice_line_oe(c_oe),
        .holdover_line_in(h_wire), .holdover_line_out(h_out),
        .holdover_line_oe(h_oe), .tuning_word(tuning_word),
        .comparator_tick(tick), .in_servo(in_servo));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Long enough for every scenario with a wide margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic pause(input int n);
        repeat (n) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Estimate is the first word written; servo only follows it
    task automatic t_estimate();
        int k;
        k = 0;
        while (tuning_word === FTW_RESET && k < 2000) begin
            @(negedge clk);
            k++;
        end
        check(in_servo, 1'b0);
        // Scale 4096 times ratio 8 over a 32-cycle divided period
        check(tuning_word, 32'h0000_0400);
        pause(4);
        check(in_servo, 1'b1);
    endtask
    // Divided tick rate for several ratios, ten ticks per window
    task automatic t_ratio();
        logic [FTW_W-1:0] w0;
        int n;
        for (int r = 1; r <= 5; r += 2) begin
            @(posedge clk) ff_ratio <= DIV_W'(r);
            pause(200);
            n = 0;
            repeat (80 * r) begin
                @(negedge clk);
                n += tick;
            end
            check(n, 10);
        end
        w0 = tuning_word;
        pause(600);
        check(tuning_word !== w0, 1'b1);
    endtask
    // Forced holdover freezes the averaged word while the clock runs
    task automatic t_hold_manual();
        logic [FTW_W-1:0] w0;
        @(posedge clk) hold_drive <= 1'b1;
        pause(10);
        check(h_oe, 1'b0);
        check(in_servo, 1'b0);
        w0 = tuning_word;
        pause(300);
        check(tuning_word, w0);
        check(tuning_word !== FTW_RESET, 1'b1);
        @(posedge clk) hold_drive <= 1'b0;
        pause(10);
    endtask
    // Automatic pick of the live reference, then back to outside control
    task automatic t_switch();
        @(posedge clk) begin
            auto_switchover <= 1'b1;
            ref_a_lost <= 1'b1;
        end
        pause(10);
        check(c_oe, 1'b1);
        check(c_wire, REF_B);
        @(posedge clk) begin
            auto_switchover <= 1'b0;
            ref_a_lost <= 1'b0;
        end
        pause(10);
        check(c_oe, 1'b0);
        check(c_out, REF_A);
        @(posedge clk) choice_drive <= 1'b1;
        pause(10);
        check(c_out, REF_B);
        @(posedge clk) choice_drive <= 1'b0;
        pause(10);
    endtask
    // Both references lost: device enters holdover and reports it
    task automatic t_hold_auto();
        @(posedge clk) begin
            auto_holdover <= 1'b1;
            ref_a_lost <= 1'b1;
            ref_b_lost <= 1'b1;
        end
        pause(10);
        check(h_oe, 1'b1);
        check(h_wire, 1'b1);
        check(in_servo, 1'b0);
    endtask
    // Reset again with the estimator off: servo starts straight from idle
    task automatic t_no_estimate();
        @(posedge clk) begin
            auto_holdover <= 1'b0;
            ref_a_lost <= 1'b0;
            ref_b_lost <= 1'b0;
            est_en <= 1'b0;
            resetn <= 1'b0;
        end
        pause(1);
        check(tuning_word, FTW_RESET);
        check(in_servo, 1'b0);
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        // Estimating would take two divided periods; servo alone needs four edges
        pause(8);
        check(in_servo, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        t_estimate();
        t_ratio();
        t_hold_manual();
        t_switch();
        t_hold_auto();
        t_no_estimate();
        end_sim();
    end
endmodule // tb
`default_nettype wire
